/* File: hdl/maf_pkg.sv */
// Constants for the station address and hash filter register bank.
// Assumes a 32-bit classic Wishbone slave on one 100 MHz clock.
package maf_pkg;
    localparam logic [7:0] MAF_OFS_STA_LO = 8'ha4;
    localparam logic [7:0] MAF_OFS_STA_HI = 8'ha8;
    localparam logic [7:0] MAF_OFS_GRP_LO = 8'hac;
    localparam logic [7:0] MAF_OFS_GRP_HI = 8'hb0;
    localparam logic [7:0] MAF_OFS_IND_LO = 8'hb4;
    localparam logic [7:0] MAF_OFS_IND_HI = 8'hb8;
    localparam logic [7:0] MAF_OFS_MODE = 8'hfc;
    localparam int MAF_BIT_SPEED = 31;
    localparam int MAF_BIT_DUPLEX = 30;
    localparam int MAF_BIT_LINK = 29;
    localparam int MAF_BIT_RELOAD = 26;
    localparam logic [2:0] MAF_RX_STOPPED = 3'h0;
    localparam logic [2:0] MAF_MODE_RESET = 3'h7;
    localparam logic [2:0] MAF_MODE_SINGLE = 3'h7;
    localparam logic [2:0] MAF_MODE_MAC_ONLY = 3'h4;
    localparam logic [31:0] MAF_HASH_RESET = 32'h0000_0000;
    localparam logic [31:0] MAF_STA_HI_MASK = 32'h0000_ffff;
endpackage : maf_pkg

/* File: hdl/maf_hash_lookup.sv */
// One 64-entry hash table lookup, registered.
// Assumes the index is already on the block's clock.
`timescale 1ns/1ps
module maf_hash_lookup (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [31:0] table_lo,
    input wire logic [31:0] table_hi,
    input wire logic lookup_valid,
    input wire logic [5:0] crc_index,
    output logic hit
);
    // Bit 5 picks the word, bits 4..0 the position
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit <= 1'b0;
        end else if (ce) begin
            if (lookup_valid) begin
                hit <= crc_index[5] ? table_hi[crc_index[4:0]]
                    : table_lo[crc_index[4:0]];
            end else begin
                hit <= 1'b0;
            end
        end
    end
endmodule : maf_hash_lookup

/* File: hdl/maf_regs.sv */
// Station address, hash tables and mode register bank.
// Assumes the EEPROM reader, CRC unit and receive engine share clk.
`timescale 1ns/1ps
module maf_regs
    import maf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] rx_state,
    input wire logic speed_100_pin,
    input wire logic duplex_full_pin,
    input wire logic link_up_pin,
    input wire logic ee_load_valid,
    input wire logic [47:0] ee_station_addr,
    input wire logic ee_reload_done,
    output logic ee_reload_start,
    input wire logic lookup_valid,
    input wire logic [5:0] crc_index,
    output logic group_hit,
    output logic individual_hit,
    output logic mii_on_rom_pins,
    output logic [2:0] chip_mode_select
);
    logic [31:0] station_addr_low_reg;
    logic [31:0] station_addr_high_reg;
    logic [31:0] group_hash_low_reg;
    logic [31:0] group_hash_high_reg;
    logic [31:0] individual_hash_low_reg;
    logic [31:0] individual_hash_high_reg;
    logic [2:0] chip_mode_reg;
    logic eeprom_reload_trigger_reg;
    logic [2:0] status_sync1_reg;
    logic [2:0] status_sync2_reg;
    logic [31:0] wmask;
    logic bus_req;
    logic wr_strobe;
    logic rx_stopped;
    logic [31:0] rd_next;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_strobe = bus_req && wb_we_i;
    assign rx_stopped = (rx_state == MAF_RX_STOPPED);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Link status pins come from the transceiver domain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_sync1_reg <= 3'h0;
            status_sync2_reg <= 3'h0;
        end else if (ce) begin
            status_sync1_reg <= {speed_100_pin, duplex_full_pin, link_up_pin};
            status_sync2_reg <= status_sync1_reg;
        end
    end

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= bus_req;
        end
    end

    // Station address: EEPROM load beats a host write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            station_addr_low_reg <= 32'h0000_0000;
            station_addr_high_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (ee_load_valid) begin
                station_addr_low_reg <= ee_station_addr[31:0];
                station_addr_high_reg <= {16'h0000, ee_station_addr[47:32]};
            end else if (wr_strobe && rx_stopped) begin
                if (wb_adr_i == MAF_OFS_STA_LO) begin
                    station_addr_low_reg <= (station_addr_low_reg & ~wmask) | (wb_dat_i & wmask);
                end
                if (wb_adr_i == MAF_OFS_STA_HI) begin
                    station_addr_high_reg <= ((station_addr_high_reg & ~wmask)
                        | (wb_dat_i & wmask)) & MAF_STA_HI_MASK;
                end
            end
        end
    end

    // Hash tables, writable only with receive stopped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            group_hash_low_reg <= MAF_HASH_RESET;
            group_hash_high_reg <= MAF_HASH_RESET;
            individual_hash_low_reg <= MAF_HASH_RESET;
            individual_hash_high_reg <= MAF_HASH_RESET;
        end else if (ce && wr_strobe && rx_stopped) begin
            unique case (wb_adr_i)
                MAF_OFS_GRP_LO: begin
                    group_hash_low_reg <= (group_hash_low_reg & ~wmask) | (wb_dat_i & wmask);
                end
                MAF_OFS_GRP_HI: begin
                    group_hash_high_reg <= (group_hash_high_reg & ~wmask) | (wb_dat_i & wmask);
                end
                MAF_OFS_IND_LO: begin
                    individual_hash_low_reg <= (individual_hash_low_reg & ~wmask) | (wb_dat_i & wmask);
                end
                MAF_OFS_IND_HI: begin
                    individual_hash_high_reg <= (individual_hash_high_reg & ~wmask) | (wb_dat_i & wmask);
                end
                default: ;
            endcase
        end
    end

    // Mode bits; reload set wins over done in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chip_mode_reg <= MAF_MODE_RESET;
            eeprom_reload_trigger_reg <= 1'b0;
            ee_reload_start <= 1'b0;
        end else if (ce) begin
            ee_reload_start <= 1'b0;
            if (wr_strobe && wb_adr_i == MAF_OFS_MODE && wb_sel_i[0]) begin
                chip_mode_reg <= wb_dat_i[2:0];
            end
            if (wr_strobe && wb_adr_i == MAF_OFS_MODE && wb_sel_i[3] && wb_dat_i[MAF_BIT_RELOAD]
                    && !eeprom_reload_trigger_reg) begin
                eeprom_reload_trigger_reg <= 1'b1;
                ee_reload_start <= 1'b1;
            end else if (ee_reload_done) begin
                eeprom_reload_trigger_reg <= 1'b0;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (wb_adr_i)
            MAF_OFS_STA_LO: rd_next = station_addr_low_reg;
            MAF_OFS_STA_HI: rd_next = station_addr_high_reg;
            MAF_OFS_GRP_LO: rd_next = group_hash_low_reg;
            MAF_OFS_GRP_HI: rd_next = group_hash_high_reg;
            MAF_OFS_IND_LO: rd_next = individual_hash_low_reg;
            MAF_OFS_IND_HI: rd_next = individual_hash_high_reg;
            MAF_OFS_MODE: begin
                rd_next[MAF_BIT_SPEED] = status_sync2_reg[2];
                rd_next[MAF_BIT_DUPLEX] = status_sync2_reg[1];
                rd_next[MAF_BIT_LINK] = status_sync2_reg[0];
                rd_next[MAF_BIT_RELOAD] = eeprom_reload_trigger_reg;
                rd_next[2:0] = chip_mode_reg;
            end
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Read data registered with the ack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce && bus_req) begin
            wb_dat_o <= rd_next;
        end
    end

    // Mode outputs registered so pin muxing sees clean levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mii_on_rom_pins <= 1'b0;
            chip_mode_select <= MAF_MODE_RESET;
        end else if (ce) begin
            mii_on_rom_pins <= (chip_mode_reg == MAF_MODE_MAC_ONLY);
            chip_mode_select <= chip_mode_reg;
        end
    end

    maf_hash_lookup u_group_lookup (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .table_lo(group_hash_low_reg),
        .table_hi(group_hash_high_reg),
        .lookup_valid(lookup_valid),
        .crc_index(crc_index),
        .hit(group_hit)
    );

    maf_hash_lookup u_individual_lookup (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .table_lo(individual_hash_low_reg),
        .table_hi(individual_hash_high_reg),
        .lookup_valid(lookup_valid),
        .crc_index(crc_index),
        .hit(individual_hit)
    );

    // Checks
    a_sta_write_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_strobe && !rx_stopped && !ee_load_valid && wb_adr_i == MAF_OFS_STA_LO)
        |=> $stable(station_addr_low_reg))
        else $error("station address changed while receive running");
    a_grp_write_gated: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_strobe && !rx_stopped)
        |=> $stable(group_hash_low_reg) && $stable(group_hash_high_reg))
        else $error("group hash changed while receive running");
    a_sta_hi_reserved: assert property (@(posedge clk) disable iff (!rst_n)
        station_addr_high_reg[31:16] == 16'h0000)
        else $error("reserved station bits set");
    a_eeprom_load: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && ee_load_valid) |=> station_addr_low_reg == $past(ee_station_addr[31:0]))
        else $error("eeprom load not taken");
    a_reload_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && ee_reload_done && eeprom_reload_trigger_reg && !ee_reload_start && !wr_strobe)
        |=> !eeprom_reload_trigger_reg)
        else $error("reload bit not cleared");
    a_reload_start: assert property (@(posedge clk) disable iff (!rst_n)
        ee_reload_start |-> eeprom_reload_trigger_reg)
        else $error("reload pulse without bit");
    a_group_hit: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && lookup_valid && crc_index[5])
        |=> group_hit == $past(group_hash_high_reg[crc_index[4:0]]))
        else $error("group hit wrong");
    a_mac_only_pins: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && chip_mode_reg == MAF_MODE_MAC_ONLY) |=> mii_on_rom_pins)
        else $error("mii not routed in mac only mode");
    a_ack_one: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wb_ack_o) |=> !wb_ack_o)
        else $error("ack held two cycles");
    c_write_stopped: cover property (@(posedge clk) disable iff (!rst_n) wr_strobe && rx_stopped);
    c_write_blocked: cover property (@(posedge clk) disable iff (!rst_n) wr_strobe && !rx_stopped);
    c_reload: cover property (@(posedge clk) disable iff (!rst_n) ee_reload_start ##[1:50] ee_reload_done);
    c_hit: cover property (@(posedge clk) disable iff (!rst_n) individual_hit);
endmodule : maf_regs

/* File: sim/maf_regs_tb_top.sv */
// Self-checking bench for the station address and hash filter register bank.
// Assumes the design answers each Wishbone request with a one-cycle ack.
`timescale 1ns/1ps
module maf_regs_tb_top;
    import maf_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, ee_reload_start, group_hit, individual_hit, mii_on_rom_pins;
    logic [2:0] chip_mode_select;
    logic [2:0] rx_state = 3'h0;
    logic speed_100_pin = 1'b0, duplex_full_pin = 1'b0, link_up_pin = 1'b0;
    logic ee_load_valid = 1'b0, ee_reload_done = 1'b0, lookup_valid = 1'b0;
    logic [47:0] ee_station_addr = 48'h0000_0000_0000;
    logic [5:0] crc_index = 6'h00;
    int err_total = 0, num_checks = 0, cycles = 0, starts = 0;

    maf_regs DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_state(rx_state),
        .speed_100_pin(speed_100_pin), .duplex_full_pin(duplex_full_pin),
        .link_up_pin(link_up_pin), .ee_load_valid(ee_load_valid),
        .ee_station_addr(ee_station_addr), .ee_reload_done(ee_reload_done),
        .ee_reload_start(ee_reload_start), .lookup_valid(lookup_valid), .crc_index(crc_index),
        .group_hit(group_hit), .individual_hit(individual_hit),
        .mii_on_rom_pins(mii_on_rom_pins), .chip_mode_select(chip_mode_select));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (ee_reload_start === 1'b1) starts++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One classic cycle; waits for ack under a bound, takes data at the ack edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                            input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
        wb_adr_i <= adr; wb_sel_i <= sel; wb_dat_i <= dat;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) chk("wb_ack", 32'h1, 32'h0);
        @(posedge clk);
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dat);
        logic [31:0] d;
        wb_cycle(1'b1, adr, sel, dat, d);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 4'hf, 32'h0000_0000, d);
        chk(nm, exp, d);
    endtask : rd_chk

    // One lookup pulse; hits are judged in the cycle after it
    task automatic look(input logic [5:0] idx, input logic g, input logic i);
        @(posedge clk);
        lookup_valid <= 1'b1; crc_index <= idx;
        @(posedge clk);
        lookup_valid <= 1'b0;
        #1;
        chk("group_hit", {31'h0, g}, {31'h0, group_hit});
        chk("individual_hit", {31'h0, i}, {31'h0, individual_hit});
    endtask : look

    task automatic t_reset();
        rd_chk("mode", MAF_OFS_MODE, 32'h0000_0007);
        chk("chip_mode", 32'h7, {29'h0, chip_mode_select});
        rd_chk("grp_lo", MAF_OFS_GRP_LO, 32'h0000_0000);
        rd_chk("grp_hi", MAF_OFS_GRP_HI, 32'h0000_0000);
        rd_chk("ind_lo", MAF_OFS_IND_LO, 32'h0000_0000);
        rd_chk("ind_hi", MAF_OFS_IND_HI, 32'h0000_0000);
        rd_chk("unmapped", 8'hc0, 32'h0000_0000);
    endtask : t_reset

    // Address 00-00-e8-11-22-33, first byte lowest
    task automatic t_eeprom();
        @(posedge clk);
        ee_load_valid <= 1'b1; ee_station_addr <= 48'h3322_11e8_0000;
        @(posedge clk);
        ee_load_valid <= 1'b0;
        rd_chk("sta_lo", MAF_OFS_STA_LO, 32'h11e8_0000);
        rd_chk("sta_hi", MAF_OFS_STA_HI, 32'h0000_3322);
    endtask : t_eeprom

    // Station address and hash writes while receive runs are dropped; reserved upper half stays zero
    task automatic t_gating();
        rx_state <= 3'h3;
        wr(MAF_OFS_STA_LO, 4'hf, 32'hdead_beef);
        wr(MAF_OFS_GRP_LO, 4'hf, 32'hffff_ffff);
        rd_chk("sta_lo_busy", MAF_OFS_STA_LO, 32'h11e8_0000);
        rd_chk("grp_lo_busy", MAF_OFS_GRP_LO, 32'h0000_0000);
        rx_state <= 3'h0;
        wr(MAF_OFS_STA_LO, 4'h1, 32'hdead_beef);
        wr(MAF_OFS_STA_HI, 4'hf, 32'hffff_ffff);
        wr(8'hc0, 4'hf, 32'hffff_ffff);
        rd_chk("sta_lo_lane", MAF_OFS_STA_LO, 32'h11e8_00ef);
        rd_chk("sta_hi_rsv", MAF_OFS_STA_HI, 32'h0000_ffff);
        rd_chk("unmapped_wr", 8'hc0, 32'h0000_0000);
    endtask : t_gating

    // Clock enable low must swallow an EEPROM load pulse
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0; ee_load_valid <= 1'b1; ee_station_addr <= 48'h0000_0000_0000;
        @(posedge clk);
        ce <= 1'b1; ee_load_valid <= 1'b0;
        rd_chk("sta_lo_frozen", MAF_OFS_STA_LO, 32'h11e8_00ef);
    endtask : t_freeze

    // Index bit 5 picks the word, bits 4..0 the bit inside it
    task automatic t_lookup();
        wr(MAF_OFS_GRP_LO, 4'hf, 32'h0000_0004);
        wr(MAF_OFS_GRP_HI, 4'hf, 32'h0000_0010);
        wr(MAF_OFS_IND_HI, 4'hf, 32'h8000_0000);
        rd_chk("grp_hi_rw", MAF_OFS_GRP_HI, 32'h0000_0010);
        rd_chk("ind_hi_rw", MAF_OFS_IND_HI, 32'h8000_0000);
        look(6'd2, 1'b1, 1'b0);
        look(6'd36, 1'b1, 1'b0);
        look(6'd34, 1'b0, 1'b0);
        look(6'd63, 1'b0, 1'b1);
    endtask : t_lookup

    task automatic t_mode();
        speed_100_pin <= 1'b1; duplex_full_pin <= 1'b1; link_up_pin <= 1'b1;
        repeat (4) @(posedge clk);
        wr(MAF_OFS_MODE, 4'h1, 32'h0000_0004);
        #1;
        chk("chip_mode_mac", 32'h4, {29'h0, chip_mode_select});
        chk("mii_on_rom", 32'h1, {31'h0, mii_on_rom_pins});
        wr(MAF_OFS_MODE, 4'h8, 32'h0400_0000);
        rd_chk("mode_reload", MAF_OFS_MODE, 32'he400_0004);
        chk("reload_starts", 32'h1, starts);
        @(posedge clk);
        ee_reload_done <= 1'b1;
        @(posedge clk);
        ee_reload_done <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk("mode_done", MAF_OFS_MODE, 32'he000_0004);
    endtask : t_mode

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_eeprom();
        t_gating();
        t_freeze();
        t_lookup();
        t_mode();
        finish_test();
    end
endmodule : maf_regs_tb_top
